// *** hw/ecl_pkg.sv ***
`default_nettype none

package ecl_pkg;

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // Image layout.

    localparam int unsigned IMG_BYTES      = 34;
    localparam logic [7:0]  SIG_PROGRAMMED = 8'hA5;
    localparam logic [5:0]  OFF_SIG        = 6'h00;
    localparam logic [5:0]  OFF_MAC_FIRST  = 6'h01;
    localparam logic [5:0]  OFF_MAC_LAST   = 6'h06;
    localparam logic [5:0]  OFF_FS_POLL    = 6'h07;
    localparam logic [5:0]  OFF_HS_POLL    = 6'h08;
    localparam logic [5:0]  OFF_FLAGS0     = 6'h09;
    localparam logic [5:0]  OFF_LANG_LO    = 6'h0A;
    localparam logic [5:0]  OFF_LANG_HI    = 6'h0B;
    localparam logic [5:0]  OFF_DESC_FIRST = 6'h0C;
    localparam logic [5:0]  OFF_DESC_LAST  = 6'h1D;
    localparam logic [5:0]  OFF_WAKE_LO    = 6'h1E;
    localparam logic [5:0]  OFF_WAKE_HI    = 6'h1F;
    localparam logic [5:0]  OFF_WAKE_FLAGS = 6'h20;
    localparam logic [5:0]  OFF_FLAGS1     = 6'h21;
    localparam int unsigned DESC_PAIRS     = 9;
    localparam int unsigned DESC_BYTES     = 18;
    localparam int unsigned EE_ADDR_W      = 9;

    // Built-in image used when the signature is wrong: MAC all ones, polls 01h and 04h, flags 1Bh.
    localparam logic [IMG_BYTES-1:0][7:0] DEF_IMG = {192'h0, 8'h1B, 8'h04, 8'h01, 48'hFFFF_FFFF_FFFF, 8'h00};

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // Register map.

    localparam int unsigned APB_ADDR_W   = 8;
    localparam logic [7:0]  REG_CTRL     = 8'h00;
    localparam logic [7:0]  REG_STATUS   = 8'h04;
    localparam logic [7:0]  REG_MAC_LO   = 8'h08;
    localparam logic [7:0]  REG_MAC_HI   = 8'h0C;
    localparam logic [7:0]  REG_USB      = 8'h10;
    localparam logic [7:0]  REG_WAKE     = 8'h14;
    localparam int unsigned CTRL_FULL    = 0;
    localparam int unsigned CTRL_MAC     = 1;
    localparam int unsigned STAT_READY   = 0;
    localparam int unsigned STAT_BUSY    = 1;
    localparam int unsigned STAT_PROG    = 2;

    typedef enum logic [1:0] {
        ECL_SIG_RD,
        ECL_IMG_RD,
        ECL_READY,
        ECL_DESC_RD
    } ecl_state_t;

    typedef struct packed {
        ecl_state_t                 st;
        logic                       full;
        logic [5:0]                 addr;
        logic [IMG_BYTES-1:0][7:0]  img;
        logic                       programmed;
        logic                       pend_full;
        logic                       pend_mac;
        logic                       ee_req;
        logic [EE_ADDR_W-1:0]       ee_addr;
        logic [7:0]                 desc_data;
        logic                       desc_valid;
        logic                       desc_none;
        logic [31:0]                prdata;
        logic                       pslverr;
    } ecl_loader_st_t;

    localparam ecl_loader_st_t ECL_RESET_ST = '{
        st: ECL_SIG_RD, full: 1'b1, addr: 6'h00, img: DEF_IMG, programmed: 1'b0,
        pend_full: 1'b0, pend_mac: 1'b0, ee_req: 1'b1, ee_addr: 9'h000,
        desc_data: 8'h00, desc_valid: 1'b0, desc_none: 1'b0, prdata: 32'h0000_0000, pslverr: 1'b0
    };

    // Descriptor offsets count 16-bit words.
    function automatic logic [EE_ADDR_W-1:0] word_to_byte(input logic [7:0] word_off);
        return {word_off, 1'b0};
    endfunction

endpackage

`default_nettype wire

// *** hw/ecl_desc_locate.sv ***
`default_nettype none

module ecl_desc_locate (
    // Descriptor pointer bytes, image bytes 0Ch upward.
    input  wire logic [ecl_pkg::DESC_BYTES-1:0][7:0] table_in,
    // Request.
    input  wire logic [3:0]                          sel_in,
    input  wire logic [7:0]                          idx_in,
    // Result.
    output logic      [ecl_pkg::EE_ADDR_W-1:0]       addr_out,
    output logic                                     serve_out
);

    logic [7:0] len;
    logic [7:0] off;
    logic [4:0] pair;

    always_comb begin
        pair = {sel_in, 1'b0};
        len  = 8'h00;
        off  = 8'h00;
        if (sel_in < 4'(ecl_pkg::DESC_PAIRS)) begin
            len = table_in[pair];
            off = table_in[pair + 5'd1];
        end
        addr_out  = ecl_pkg::word_to_byte(off) + {1'b0, idx_in};
        serve_out = (len != 8'h00) && (idx_in < len);
    end

endmodule

`default_nettype wire

// *** hw/ecl_loader.sv ***
// Overview of operation
// - Programmed image bytes 01h-06h give the MAC address in stored order.
// - Byte 07h gives the full-speed interrupt polling interval.
// - Byte 08h gives the hi-speed interrupt polling interval.
// - Byte 09h loads as configuration flag byte zero.
// - Bytes 0Ah and 0Bh give the language identifier, low byte first.
// - Bytes 0Ch-15h hold length/offset pairs for five string descriptors.
// - Descriptor offsets are word offsets; byte address is twice the value.
// - Zero descriptor length means absent; its offset is ignored.
// - Bytes 16h-19h point at hi-speed device and configuration descriptors.
// - Bytes 1Ah-1Dh point at full-speed device and configuration descriptors.
// - Byte 1Eh gives wake enables for pins 7 down to 0.
// - Byte 1Fh gives wake enables for pins 11 down to 8.
// - Byte 20h loads as the power-management wake flags.
// - Byte 21h loads as configuration flag byte one.
// - Stored string descriptor bytes are served verbatim to the host.
// - After reset byte 0 is read; only A5h marks a programmed image.
// - Any other signature selects the built-in default settings.
// - USB bus reset reloads only the MAC; other resets reload everything.
//
// Our own choices: the address map and the APB slave port.
`default_nettype none

module ecl_loader (
    // Clock and reset.
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    input  wire logic        usb_bus_reset_in,
    // Image byte read port towards the serial memory controller.
    output logic             ee_rd_req_out,
    output logic [8:0]       ee_rd_addr_out,
    input  wire logic        ee_rd_ack_in,
    input  wire logic [7:0]  ee_rd_data_in,
    // Descriptor fetch from the USB device logic.
    input  wire logic        desc_req_in,
    input  wire logic [3:0]  desc_sel_in,
    input  wire logic [7:0]  desc_idx_in,
    output logic             desc_valid_out,
    output logic             desc_none_out,
    output logic [7:0]       desc_data_out,
    // Loaded settings.
    output logic             cfg_ready_out,
    output logic [47:0]      mac_out,
    output logic [7:0]       fs_poll_out,
    output logic [7:0]       hs_poll_out,
    output logic [7:0]       cfg_flags0_out,
    output logic [7:0]       cfg_flags1_out,
    output logic [15:0]      lang_id_out,
    output logic [11:0]      gpio_wake_en_out,
    output logic [7:0]       wake_event_flags_out,
    // APB slave.
    input  wire logic        apb_psel_in,
    input  wire logic        apb_penable_in,
    input  wire logic        apb_pwrite_in,
    input  wire logic [7:0]  apb_paddr_in,
    input  wire logic [31:0] apb_pwdata_in,
    output logic [31:0]      apb_prdata_out,
    output logic             apb_pready_out,
    output logic             apb_pslverr_out
);

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // State.

    ecl_pkg::ecl_loader_st_t s;
    ecl_pkg::ecl_loader_st_t next_s;
    logic [8:0]              loc_addr;
    logic                    loc_serve;
    logic                    busy;
    logic                    ee_done;
    logic [5:0]              last_addr;

    ecl_desc_locate u_locate (
        .table_in  (s.img[ecl_pkg::OFF_DESC_LAST:ecl_pkg::OFF_DESC_FIRST]),
        .sel_in    (desc_sel_in),
        .idx_in    (desc_idx_in),
        .addr_out  (loc_addr),
        .serve_out (loc_serve)
    );

    assign busy      = (s.st == ecl_pkg::ECL_SIG_RD) || (s.st == ecl_pkg::ECL_IMG_RD);
    assign ee_done   = s.ee_req && ee_rd_ack_in;
    // A bus-reset reload stops after the last MAC byte.
    assign last_addr = s.full ? ecl_pkg::OFF_FLAGS1 : ecl_pkg::OFF_MAC_LAST;

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        next_s            = s;
        next_s.desc_valid = 1'b0;
        next_s.desc_none  = 1'b0;

        unique case (s.st)
            ecl_pkg::ECL_SIG_RD: begin
                next_s.ee_req  = 1'b1;
                next_s.ee_addr = 9'h000;
                if (ee_done) begin
                    next_s.ee_req                     = 1'b0;
                    next_s.img[ecl_pkg::OFF_SIG]      = ee_rd_data_in;
                    next_s.programmed                 = (ee_rd_data_in == ecl_pkg::SIG_PROGRAMMED);
                    if (ee_rd_data_in == ecl_pkg::SIG_PROGRAMMED) begin
                        next_s.addr = ecl_pkg::OFF_MAC_FIRST;
                        next_s.st   = ecl_pkg::ECL_IMG_RD;
                    end else begin
                        // Blank memory: fall back to the built-in settings.
                        if (s.full) begin
                            next_s.img[ecl_pkg::IMG_BYTES-1:1] = ecl_pkg::DEF_IMG[ecl_pkg::IMG_BYTES-1:1];
                        end else begin
                            next_s.img[6:1] = ecl_pkg::DEF_IMG[6:1];
                        end
                        next_s.st = ecl_pkg::ECL_READY;
                    end
                end
            end
            ecl_pkg::ECL_IMG_RD: begin
                next_s.ee_req  = 1'b1;
                next_s.ee_addr = {3'b000, s.addr};
                if (ee_done) begin
                    next_s.ee_req      = 1'b0;
                    // Every byte lands in its own slot; the settings outputs pick the slots apart.
                    next_s.img[s.addr] = ee_rd_data_in;
                    if (s.addr == last_addr) begin
                        next_s.st = ecl_pkg::ECL_READY;
                    end else begin
                        next_s.addr = s.addr + 6'd1;
                    end
                end
            end
            ecl_pkg::ECL_READY: begin
                next_s.ee_req = 1'b0;
                if (s.pend_full) begin
                    next_s.st        = ecl_pkg::ECL_SIG_RD;
                    next_s.full      = 1'b1;
                    next_s.pend_full = 1'b0;
                    next_s.pend_mac  = 1'b0;
                    next_s.ee_req    = 1'b1;
                    next_s.ee_addr   = 9'h000;
                end else if (s.pend_mac) begin
                    next_s.st       = ecl_pkg::ECL_SIG_RD;
                    next_s.full     = 1'b0;
                    next_s.pend_mac = 1'b0;
                    next_s.ee_req   = 1'b1;
                    next_s.ee_addr  = 9'h000;
                end else if (desc_req_in) begin
                    if (loc_serve) begin
                        next_s.ee_req  = 1'b1;
                        next_s.ee_addr = loc_addr;
                        next_s.st      = ecl_pkg::ECL_DESC_RD;
                    end else begin
                        next_s.desc_none = 1'b1;
                    end
                end
            end
            ecl_pkg::ECL_DESC_RD: begin
                if (ee_done) begin
                    next_s.ee_req     = 1'b0;
                    next_s.desc_data  = ee_rd_data_in;
                    next_s.desc_valid = 1'b1;
                    next_s.st         = ecl_pkg::ECL_READY;
                end
            end
        endcase

        // APB: read data and error are captured in the setup cycle, so the access is zero-wait.
        if (apb_psel_in && !apb_penable_in) begin
            next_s.pslverr = 1'b0;
            unique case (apb_paddr_in)
                ecl_pkg::REG_CTRL:   next_s.prdata = 32'h0000_0000;
                ecl_pkg::REG_STATUS: next_s.prdata = {16'h0000, s.img[ecl_pkg::OFF_SIG], 5'h00,
                                                      s.programmed, busy, !busy};
                ecl_pkg::REG_MAC_LO: next_s.prdata = mac_out[31:0];
                ecl_pkg::REG_MAC_HI: next_s.prdata = {16'h0000, mac_out[47:32]};
                ecl_pkg::REG_USB:    next_s.prdata = {cfg_flags1_out, cfg_flags0_out, hs_poll_out, fs_poll_out};
                ecl_pkg::REG_WAKE:   next_s.prdata = {4'h0, gpio_wake_en_out, wake_event_flags_out, lang_id_out[7:0]};
                default: begin
                    next_s.prdata  = 32'h0000_0000;
                    next_s.pslverr = 1'b1;
                end
            endcase
        end

        // Reload requests are set after the consuming state logic so a new request is never lost.
        if (apb_psel_in && apb_penable_in && apb_pwrite_in && (apb_paddr_in == ecl_pkg::REG_CTRL)) begin
            if (apb_pwdata_in[ecl_pkg::CTRL_FULL]) begin
                next_s.pend_full = 1'b1;
            end
            if (apb_pwdata_in[ecl_pkg::CTRL_MAC]) begin
                next_s.pend_mac = 1'b1;
            end
        end
        if (usb_bus_reset_in) begin
            next_s.pend_mac = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            s <= ecl_pkg::ECL_RESET_ST;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign ee_rd_req_out        = s.ee_req;
    assign ee_rd_addr_out       = s.ee_addr;
    assign desc_valid_out       = s.desc_valid;
    assign desc_none_out        = s.desc_none;
    assign desc_data_out        = s.desc_data;
    assign cfg_ready_out        = !busy;
    assign mac_out              = {s.img[1], s.img[2], s.img[3], s.img[4], s.img[5], s.img[6]};
    assign fs_poll_out          = s.img[ecl_pkg::OFF_FS_POLL];
    assign hs_poll_out          = s.img[ecl_pkg::OFF_HS_POLL];
    assign cfg_flags0_out       = s.img[ecl_pkg::OFF_FLAGS0];
    assign lang_id_out          = {s.img[ecl_pkg::OFF_LANG_HI], s.img[ecl_pkg::OFF_LANG_LO]};
    assign gpio_wake_en_out     = {s.img[ecl_pkg::OFF_WAKE_HI][3:0],
                                   s.img[ecl_pkg::OFF_WAKE_LO]};
    assign wake_event_flags_out = s.img[ecl_pkg::OFF_WAKE_FLAGS];
    assign cfg_flags1_out       = s.img[ecl_pkg::OFF_FLAGS1];
    assign apb_prdata_out       = s.prdata;
    assign apb_pready_out       = 1'b1;
    assign apb_pslverr_out      = s.pslverr;

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // Checks. The hi-speed and full-speed descriptor pairs share the locate path.

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    property p_sig_good;
        (s.st == ecl_pkg::ECL_SIG_RD) && ee_done && (ee_rd_data_in == 8'hA5)
            |=> (s.st == ecl_pkg::ECL_IMG_RD) && (s.addr == 6'h01) && s.programmed;
    endproperty
    a_sig_good: assert property (p_sig_good) else $error("Good signature did not start the image read.");

    property p_sig_blank;
        (s.st == ecl_pkg::ECL_SIG_RD) && s.full && ee_done && (ee_rd_data_in != 8'hA5)
            |=> (mac_out == 48'hFFFF_FFFF_FFFF) && (fs_poll_out == 8'h01) && (hs_poll_out == 8'h04)
                && (cfg_flags0_out == 8'h1B) && cfg_ready_out;
    endproperty
    a_sig_blank: assert property (p_sig_blank) else $error("Blank signature did not load defaults.");

    property p_mac_last;
        (s.st == ecl_pkg::ECL_IMG_RD) && ee_done && (s.addr == 6'h06) |=> (mac_out[7:0] == $past(ee_rd_data_in));
    endproperty
    a_mac_last: assert property (p_mac_last) else $error("Last MAC byte not in the low octet.");

    property p_mac_only;
        (s.st == ecl_pkg::ECL_IMG_RD) && !s.full |-> (s.addr <= 6'h06);
    endproperty
    a_mac_only: assert property (p_mac_only) else $error("Bus-reset reload read past the MAC.");

    property p_hs_poll;
        (s.st == ecl_pkg::ECL_IMG_RD) && ee_done && (s.addr == 6'h08) |=> (hs_poll_out == $past(ee_rd_data_in));
    endproperty
    a_hs_poll: assert property (p_hs_poll) else $error("Hi-speed poll interval not loaded.");

    property p_wake_hi;
        (s.st == ecl_pkg::ECL_IMG_RD) && ee_done && (s.addr == 6'h1F)
            |=> (gpio_wake_en_out[11:8] == $past(ee_rd_data_in[3:0]));
    endproperty
    a_wake_hi: assert property (p_wake_hi) else $error("Upper wake enables not loaded.");

    property p_desc_absent;
        (s.st == ecl_pkg::ECL_READY) && !s.pend_full && !s.pend_mac && desc_req_in && !loc_serve
            |=> desc_none_out && !ee_rd_req_out && !desc_valid_out;
    endproperty
    a_desc_absent: assert property (p_desc_absent) else $error("Absent descriptor caused a read.");

    property p_desc_byte;
        (s.st == ecl_pkg::ECL_DESC_RD) && ee_done |=> desc_valid_out && (desc_data_out == $past(ee_rd_data_in));
    endproperty
    a_desc_byte: assert property (p_desc_byte) else $error("Descriptor byte not served verbatim.");

    property p_ready_rise;
        $rose(cfg_ready_out) |-> $past(ee_done);
    endproperty
    a_ready_rise: assert property (p_ready_rise) else $error("Ready rose without a finished load.");

    property p_fs_poll;
        (s.st == ecl_pkg::ECL_IMG_RD) && ee_done && (s.addr == 6'h07) |=> (fs_poll_out == $past(ee_rd_data_in));
    endproperty
    a_fs_poll: assert property (p_fs_poll) else $error("Full-speed poll interval not loaded.");

    property p_lang_hi;
        (s.st == ecl_pkg::ECL_IMG_RD) && ee_done && (s.addr == 6'h0B)
            |=> (lang_id_out[15:8] == $past(ee_rd_data_in));
    endproperty
    a_lang_hi: assert property (p_lang_hi) else $error("Language identifier high byte not loaded.");

    property p_flags1_last;
        (s.st == ecl_pkg::ECL_IMG_RD) && ee_done && (s.addr == 6'h21)
            |=> (cfg_flags1_out == $past(ee_rd_data_in)) && cfg_ready_out;
    endproperty
    a_flags1_last: assert property (p_flags1_last) else $error("Flag byte one not loaded last.");

    // Doubled word offsets are even, so the low address bit must follow the index.
    property p_desc_even;
        (s.st == ecl_pkg::ECL_READY) && !s.pend_full && !s.pend_mac && desc_req_in && loc_serve
            |=> ee_rd_req_out && (ee_rd_addr_out[0] == $past(desc_idx_in[0]));
    endproperty
    a_desc_even: assert property (p_desc_even) else $error("Descriptor address not word based.");

endmodule

`default_nettype wire

// *** test/ecl_ee_model.sv ***
`default_nettype none

module ecl_ee_model (
    // Clock and reset.
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    // Byte read port.
    input  wire logic       req_in,
    input  wire logic [8:0] addr_in,
    input  wire logic [3:0] lat_in,
    output logic            ack_out,
    output logic [7:0]      data_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] mem [0:511];
    logic [7:0] q;
    logic [3:0] cnt;
    logic       done;

    // Between answers the lines show the inverse, so a stale byte never passes for a fresh one.
    assign data_out = ack_out ? q : ~q;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ack_out <= 1'b0;
            cnt     <= 4'h0;
            done    <= 1'b0;
            q       <= 8'h00;
        end else begin
            ack_out <= 1'b0;
            if (ack_out) begin
                done <= 1'b1;
            end
            if (!req_in) begin
                done <= 1'b0;
            end else if (!done && !ack_out) begin
                if (cnt >= lat_in) begin
                    ack_out <= 1'b1;
                    q       <= mem[addr_in];
                    cnt     <= 4'h0;
                end else begin
                    cnt <= cnt + 4'h1;
                end
            end
        end
    end
endmodule

`default_nettype wire

// *** test/ecl_loader_tb.sv ***
`default_nettype none

module ecl_loader_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, rst, usb, dreq, dval, dnone, rdy, req, ack, psel, pen, pwr, prdy, perr, prog;
    logic [3:0]  dsel, lat;
    logic [7:0]  didx, ddata, edat, fs, hs, f0, f1, wf, paddr, snap [0:33];
    logic [8:0]  eaddr;
    logic [11:0] gw;
    logic [15:0] lang;
    logic [47:0] mac;
    logic [31:0] pwdata, prdata, rd;
    int          err_count, checked, reads, cyc, seed;
    logic        e;

    ecl_loader dut_u (.clk_sys_in(clk), .rst_in(rst), .usb_bus_reset_in(usb), .ee_rd_req_out(req),
        .ee_rd_addr_out(eaddr), .ee_rd_ack_in(ack), .ee_rd_data_in(edat), .desc_req_in(dreq),
        .desc_sel_in(dsel), .desc_idx_in(didx), .desc_valid_out(dval), .desc_none_out(dnone),
        .desc_data_out(ddata), .cfg_ready_out(rdy), .mac_out(mac), .fs_poll_out(fs), .hs_poll_out(hs),
        .cfg_flags0_out(f0), .cfg_flags1_out(f1), .lang_id_out(lang), .gpio_wake_en_out(gw),
        .wake_event_flags_out(wf), .apb_psel_in(psel), .apb_penable_in(pen), .apb_pwrite_in(pwr),
        .apb_paddr_in(paddr), .apb_pwdata_in(pwdata), .apb_prdata_out(prdata), .apb_pready_out(prdy),
        .apb_pslverr_out(perr));
    ecl_ee_model ee_u (.clk_in(clk), .rst_in(rst), .req_in(req), .addr_in(eaddr), .lat_in(lat),
        .ack_out(ack), .data_out(edat));

    ////////////////////////////////////////////////////////////////////////////////////////////////////

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        if (req && ack) reads++;
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            close_out();
        end
    end

    function automatic logic [7:0] m(input int i);
        return ee_u.mem[i];
    endfunction

    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Random image around the descriptor pointer set of a known good part.
    task automatic fill();
        logic [7:0] ptr [0:17] = '{8'h0A, 8'h0F, 8'h12, 8'h14, 8'h10, 8'h1D, 8'h00, 8'h55, 8'h00,
                                   8'h00, 8'h12, 8'h25, 8'h12, 8'h2E, 8'h12, 8'h37, 8'h12, 8'h40};
        for (int i = 0; i < 512; i++) ee_u.mem[i] = 8'($random(seed));
        for (int i = 0; i < 18; i++) ee_u.mem[12+i] = ptr[i];
        ee_u.mem[0] = 8'hA5;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pen    <= 1'b0;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (prdy !== 1'b1) @(posedge clk);
        rd   = prdata;
        e    = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask

    // Waits out any reload, then checks how many image bytes it read.
    task automatic wait_load(input int n_exp);
        int n;
        n = 0;
        @(negedge clk);
        while (rdy === 1'b1 && n < 20) begin @(negedge clk); n++; end
        while (rdy !== 1'b1 && n < 3000) begin @(negedge clk); n++; end
        chk("reads", reads, n_exp);
    endtask

    task automatic chk_cfg(input logic p);
        logic [15:0] g;
        g = {m(31), m(30)};
        chk("mac", mac, p ? {m(1), m(2), m(3), m(4), m(5), m(6)} : 48'hFFFF_FFFF_FFFF);
        chk("fs", fs, p ? m(7) : 8'h01);
        chk("hs", hs, p ? m(8) : 8'h04);
        chk("flags0", f0, p ? m(9) : 8'h1B);
        chk("lang", lang, p ? {m(11), m(10)} : 16'h0000);
        chk("gpio", gw, p ? g[11:0] : 12'h000);
        chk("wake", wf, p ? m(32) : 8'h00);
        chk("flags1", f1, p ? m(33) : 8'h00);
    endtask

    task automatic desc(input logic [3:0] s, input logic [7:0] i);
        logic [7:0] len, off;
        logic       ne;
        int         n;
        len = (prog && s < 9) ? m(12 + 2 * s) : 8'h00;
        off = (s < 9) ? m(13 + 2 * s) : 8'h00;
        ne  = (len == 8'h00) || (i >= len);
        @(posedge clk);
        dreq <= 1'b1;
        dsel <= s;
        didx <= i;
        @(posedge clk);
        dreq <= 1'b0;
        n = 0;
        @(negedge clk);
        while (dval !== 1'b1 && dnone !== 1'b1 && n < 60) begin @(negedge clk); n++; end
        chk("dresp", dval | dnone, 1'b1);
        chk("dnone", dnone, ne);
        if (!ne) chk("ddata", ddata, m(({1'b0, off} * 2 + i) % 512));
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////////////////

    initial begin
        logic [7:0] l;
        logic [7:0] bad [0:2];
        bad = '{8'h00, 8'hFF, 8'hA4};
        {rst, usb, dreq, dsel, didx, psel, pen, pwr, paddr, pwdata, lat} = '0;
        rst = 1'b1;
        {err_count, checked, reads, cyc} = '0;
        seed = 32'h71c4;
        prog = 1'b1;
        fill();
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        wait_load(34);
        chk_cfg(1'b1);
        apb(1'b0, ecl_pkg::REG_STATUS, 32'h0);
        chk("status", {rd[15:8], rd[2:0]}, {8'hA5, 3'b101});
        apb(1'b0, ecl_pkg::REG_MAC_LO, 32'h0);
        chk("mac_lo", rd, {m(3), m(4), m(5), m(6)});
        apb(1'b0, ecl_pkg::REG_MAC_HI, 32'h0);
        chk("mac_hi", rd, {16'h0000, m(1), m(2)});
        apb(1'b0, ecl_pkg::REG_WAKE, 32'h0);
        chk("wake_reg", rd, {4'h0, 4'(m(31)), m(30), m(32), m(10)});
        apb(1'b0, ecl_pkg::REG_USB, 32'h0);
        chk("usb", rd, {m(33), m(9), m(8), m(7)});
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped", {e, rd}, 33'h1_0000_0000);
        $display("test load done");
        // Both edges of every length, plus a random index.
        for (int s = 0; s < 10; s++) begin
            l = (s < 9) ? m(12 + 2 * s) : 8'h00;
            desc(4'(s), 8'h00);
            desc(4'(s), l - 8'h01);
            desc(4'(s), l);
            desc(4'(s), 8'($random(seed)));
        end
        $display("test descriptors done");
        for (int i = 0; i < 34; i++) snap[i] = m(i);
        lat = 4'h5;
        // First a bus reset, then the register-requested MAC-only reload.
        for (int k = 0; k < 2; k++) begin
            for (int i = 1; i < 34; i++) ee_u.mem[i] = 8'($random(seed));
            reads = 0;
            if (k == 0) begin
                @(posedge clk);
                usb <= 1'b1;
                @(posedge clk);
                usb <= 1'b0;
            end else begin
                apb(1'b1, ecl_pkg::REG_CTRL, 32'h2);
            end
            wait_load(7);
            chk("mac_usb", mac, {m(1), m(2), m(3), m(4), m(5), m(6)});
            chk("fs_kept", fs, snap[7]);
            chk("flags1_kept", f1, snap[33]);
        end
        $display("test bus reset done");
        for (int k = 0; k < 3; k++) begin
            fill();
            lat   = 4'($random(seed));
            reads = 0;
            apb(1'b1, ecl_pkg::REG_CTRL, 32'h1);
            wait_load(34);
            chk_cfg(1'b1);
            desc(4'($unsigned($random(seed)) % 9), 8'($random(seed) % 20));
        end
        $display("test reload done");
        // Wrong signatures: one read only, then built-in values and no descriptors.
        for (int k = 0; k < 3; k++) begin
            ee_u.mem[0] = bad[k];
            prog  = 1'b0;
            reads = 0;
            // The first pass reloads over a programmed image, so the defaults must overwrite it.
            if (k == 0) begin
                apb(1'b1, ecl_pkg::REG_CTRL, 32'h1);
            end else begin
                @(posedge clk);
                rst <= 1'b1;
                repeat (5) @(posedge clk);
                rst <= 1'b0;
            end
            wait_load(1);
            chk_cfg(1'b0);
            desc(4'h0, 8'h00);
        end
        $display("test blank done");
        close_out();
    end
endmodule

`default_nettype wire
